//--- gsa_pkg.sv
// Purpose: Shared constants for the gain, status and slave address register logic.
// Assumes: 16-bit register words addressed by a 5-bit register address.
// Notes:   Field positions are counted from bit 0 of the register word.

`default_nettype none

package gsa_pkg;

	// ==========================================================
	// Register map
	localparam int             REG_ADDR_W    = 5;
	localparam int             DATA_W        = 16;
	localparam logic [4:0]     ADDR_VOL_GAIN = 5'h0a;
	localparam logic [4:0]     ADDR_NV_GAIN  = 5'h1a;

	// ==========================================================
	// Field positions
	localparam int             POS_GAIN0     = 8;   // Channel n gain at POS_GAIN0 + n
	localparam int             POS_PWR_EVT   = 7;
	localparam int             POS_NV_ACTIVE = 6;
	localparam int             POS_LOCK      = 7;
	localparam int             SLAVE_ADDR_W  = 7;

	// ==========================================================
	// Reference encoding
	localparam int             REF_SEL_W     = 2;
	localparam logic [1:0]     REF_SUPPLY    = 2'h0;  // Supply rail used as reference

	// ==========================================================
	// Reset values
	localparam logic           RST_VOL_GAIN  = 1'b0;
	localparam logic           RST_PWR_EVT   = 1'b1;
	localparam logic           RST_NV_GAIN   = 1'b0;
	localparam logic           RST_LOCK      = 1'b0;
	localparam logic [6:0]     RST_SLAVE_ADR = 7'h00;

endpackage : gsa_pkg

`default_nettype wire

//--- gsa_gain_apply.sv
// Purpose: Per-channel effective output gain from gain bit and reference choice.
// Assumes: Inputs come from logic on ref_clk.
// Notes:   One register stage, so gain changes show one cycle after the cause.

`timescale 1ns/1ps
`default_nettype none

module gsa_gain_apply #(
	parameter int NUM_CHAN = 2
) (
	// Clock and reset
	input  wire logic                                      ref_clk,
	input  wire logic                                      srst,
	// Per-channel controls
	input  wire logic [NUM_CHAN-1:0]                       gainSel,
	input  wire logic [gsa_pkg::REF_SEL_W*NUM_CHAN-1:0]    refSel,
	// Effective gain, high for double gain
	output var  logic [NUM_CHAN-1:0]                       doubleGain_ff
);

	// ==========================================================
	// Gain resolution per channel
	logic [NUM_CHAN-1:0] nxt_doubleGain;

	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHAN; ch++)
		begin : g_chan
			// Supply reference forces unity gain whatever the bit holds
			assign nxt_doubleGain[ch] = gainSel[ch] &&
				(refSel[ch*gsa_pkg::REF_SEL_W +: gsa_pkg::REF_SEL_W] != gsa_pkg::REF_SUPPLY); // [RQ4]
		end
	endgenerate

	// Registered so the analog control never sees decode glitches
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			doubleGain_ff <= '0;
		else
			doubleGain_ff <= nxt_doubleGain;
	end

endmodule : gsa_gain_apply

`default_nettype wire

//--- gsa_regs.sv
// Purpose: Volatile gain/status word and nonvolatile gain/slave address word.
// Assumes: Register port driven by the serial protocol engine on ref_clk;
//          srst is the power-on / brown-out reset of the device.
// Notes:   Reads answer one cycle after the strobe; a read clears the power flag
//          only after its value has been captured into the read data.

`timescale 1ns/1ps
`default_nettype none

// Operation
// [RQ1] Unimplemented gain/status bits always read zero
// [RQ2] Bit 9 picks second channel double gain
// [RQ3] Bit 8 picks first channel double gain
// [RQ4] Supply reference forces unity gain per channel
// [RQ5] Bit 7 shows power event since read
// [RQ6] Reading gain/status clears the power flag
// [RQ7] Bit 6 shows nonvolatile write in progress
// [RQ8] During nonvolatile write, only volatile commands
// [RQ9] Nonvolatile gain word lives at 1Ah
// [RQ10] Nonvolatile word carries lock status and address
// [RQ11] Volatile gain/status word lives at 0Ah
// [RQ12] Lock status mirrors config; lock freezes address
// [RQ13] Low seven bits hold slave address
// [RQ14] Power flag captured before clearing on read
module gsa_regs #(
	parameter int         NUM_CHAN       = 2,
	parameter logic [6:0] RST_SLAVE_ADDR = gsa_pkg::RST_SLAVE_ADR
) (
	// Clock and reset
	input  wire logic                                      ref_clk,
	input  wire logic                                      srst,
	// Register port from the protocol engine
	input  wire logic [gsa_pkg::REG_ADDR_W-1:0]            regAddr,
	input  wire logic                                      regWr,
	input  wire logic [gsa_pkg::DATA_W-1:0]                regWrData,
	input  wire logic                                      regRd,
	output var  logic [gsa_pkg::DATA_W-1:0]                readData_ff,
	output var  logic                                      readValid_ff,
	output var  logic                                      readHit_ff,
	output var  logic                                      cmdRefused_ff,
	// Device status and configuration inputs
	input  wire logic                                      porEvent,
	input  wire logic                                      nvWriteActive,
	input  wire logic [gsa_pkg::REF_SEL_W*NUM_CHAN-1:0]    chanRefSel,
	input  wire logic                                      lockSetCmd,
	input  wire logic                                      hvUnlockCmd,
	// Gain controls toward the output drivers
	output var  logic [NUM_CHAN-1:0]                       chanDoubleGain_ff,
	// Nonvolatile image and write request toward the memory engine
	output var  logic [NUM_CHAN-1:0]                       nvGainSel_ff,
	output var  logic [gsa_pkg::SLAVE_ADDR_W-1:0]          slaveAddrBits_ff,
	output var  logic                                      addrLockStatus_ff,
	output var  logic                                      nvWriteReq_ff,
	output var  logic [gsa_pkg::DATA_W-1:0]                nvWriteData_ff
);

	// ==========================================================
	// Widths derived from the channel count
	localparam int UPPER_W = gsa_pkg::DATA_W - gsa_pkg::POS_GAIN0 - NUM_CHAN;
	localparam int NV_UP_W = gsa_pkg::DATA_W - gsa_pkg::POS_GAIN0 - NUM_CHAN;

	// ==========================================================
	// State
	logic [NUM_CHAN-1:0] volGainSel_ff;   // Volatile gain bits
	logic                pwrEvt_ff;       // Power event flag, clear on read

	// ==========================================================
	// Address decode
	wire logic hitVol      = (regAddr == gsa_pkg::ADDR_VOL_GAIN); // [RQ11]
	wire logic hitNv       = (regAddr == gsa_pkg::ADDR_NV_GAIN);  // [RQ9]
	wire logic wrVol       = regWr && hitVol;
	wire logic rdVol       = regRd && hitVol;
	// Nonvolatile access blocked while the memory engine is busy
	wire logic nvBusy      = nvWriteActive;
	wire logic wrNvOk      = regWr && hitNv && !nvBusy;                          // [RQ8]
	wire logic rdNvOk      = regRd && hitNv && !nvBusy;                          // [RQ8]
	wire logic nvRefused   = (regWr || regRd) && hitNv && nvBusy;                // [RQ8]
	// Address field writable only while unlocked
	wire logic wrAddrOk    = wrNvOk && !addrLockStatus_ff;                       // [RQ12]

	// ==========================================================
	// Word assembly; unused positions are tied low
	wire logic [gsa_pkg::DATA_W-1:0] volWord = {
		{UPPER_W{1'b0}},
		volGainSel_ff,
		pwrEvt_ff,                                                    // [RQ5]
		nvWriteActive,                                                // [RQ7]
		{gsa_pkg::POS_NV_ACTIVE{1'b0}}                                // [RQ1]
	};
	wire logic [gsa_pkg::DATA_W-1:0] nvWord = {
		{NV_UP_W{1'b0}},
		nvGainSel_ff,
		addrLockStatus_ff,                                            // [RQ10]
		slaveAddrBits_ff                                              // [RQ13]
	};

	// Next values of the register fields
	wire logic [NUM_CHAN-1:0] wrGain =
		regWrData[gsa_pkg::POS_GAIN0 +: NUM_CHAN];                    // [RQ2] [RQ3]
	wire logic [NUM_CHAN-1:0] nxt_volGainSel = wrVol ? wrGain : volGainSel_ff;
	wire logic [NUM_CHAN-1:0] nxt_nvGainSel  = wrNvOk ? wrGain : nvGainSel_ff;
	wire logic [gsa_pkg::SLAVE_ADDR_W-1:0] nxt_slaveAddrBits = wrAddrOk ?
		regWrData[gsa_pkg::SLAVE_ADDR_W-1:0] : slaveAddrBits_ff;      // [RQ13]
	// A fresh power event beats the clear of a read in the same cycle
	wire logic nxt_pwrEvt = porEvent ? 1'b1 : (rdVol ? 1'b0 : pwrEvt_ff); // [RQ6]
	// Unlock by high-voltage command wins over a lock request
	wire logic nxt_addrLock = hvUnlockCmd ? 1'b0 :
		(lockSetCmd ? 1'b1 : addrLockStatus_ff);                      // [RQ12]

	// Read selection; refused or unmapped reads return zero
	wire logic [gsa_pkg::DATA_W-1:0] nxt_readData =
		rdVol  ? volWord :                                            // [RQ14]
		rdNvOk ? nvWord  : '0;
	// Image sent to the memory engine; lock bit is read-only
	wire logic [gsa_pkg::DATA_W-1:0] nxt_nvWriteData = {
		{NV_UP_W{1'b0}},
		nxt_nvGainSel,
		addrLockStatus_ff,
		nxt_slaveAddrBits
	};

	// ==========================================================
	// Volatile gain and power flag; flag sets at power-up reset
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			volGainSel_ff <= {NUM_CHAN{gsa_pkg::RST_VOL_GAIN}};
			pwrEvt_ff     <= gsa_pkg::RST_PWR_EVT;                    // [RQ5]
		end
		else
		begin
			volGainSel_ff <= nxt_volGainSel;                          // [RQ2] [RQ3]
			pwrEvt_ff     <= nxt_pwrEvt;                              // [RQ6]
		end
	end

	// Nonvolatile image and lock state
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			nvGainSel_ff      <= {NUM_CHAN{gsa_pkg::RST_NV_GAIN}};
			slaveAddrBits_ff  <= RST_SLAVE_ADDR;
			addrLockStatus_ff <= gsa_pkg::RST_LOCK;
		end
		else
		begin
			nvGainSel_ff      <= nxt_nvGainSel;                       // [RQ9]
			slaveAddrBits_ff  <= nxt_slaveAddrBits;                   // [RQ12]
			addrLockStatus_ff <= nxt_addrLock;
		end
	end

	// Read answer, refusal and write request, all one cycle after the strobe
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			readData_ff    <= '0;
			readValid_ff   <= 1'b0;
			readHit_ff     <= 1'b0;
			cmdRefused_ff  <= 1'b0;
			nvWriteReq_ff  <= 1'b0;
			nvWriteData_ff <= '0;
		end
		else
		begin
			readData_ff    <= nxt_readData;                           // [RQ14]
			readValid_ff   <= regRd;
			readHit_ff     <= rdVol || rdNvOk;
			cmdRefused_ff  <= nvRefused;                              // [RQ8]
			nvWriteReq_ff  <= wrNvOk;
			nvWriteData_ff <= wrNvOk ? nxt_nvWriteData : nvWriteData_ff;
		end
	end

	// ==========================================================
	// Effective gain toward the drivers
	gsa_gain_apply #(
		.NUM_CHAN      (NUM_CHAN)
	) u_gain_apply (
		.ref_clk       (ref_clk),
		.srst          (srst),
		.gainSel       (volGainSel_ff),
		.refSel        (chanRefSel),
		.doubleGain_ff (chanDoubleGain_ff)
	);

	// ==========================================================
	// Assertions
	property p_zeroBits;
		@(posedge ref_clk) disable iff (srst)
		rdVol |=> (readData_ff[gsa_pkg::POS_NV_ACTIVE-1:0] == '0) &&
			(readData_ff[gsa_pkg::DATA_W-1:gsa_pkg::POS_GAIN0+NUM_CHAN] == '0);
	endproperty
	a_zeroBits: assert property (p_zeroBits) else $error("unused bits not zero"); // [RQ1]

	property p_gain0;
		@(posedge ref_clk) disable iff (srst)
		wrVol |=> (volGainSel_ff[0] == $past(regWrData[gsa_pkg::POS_GAIN0]));
	endproperty
	a_gain0: assert property (p_gain0) else $error("first gain bit not stored"); // [RQ3]

	generate
		if (NUM_CHAN > 1)
		begin : g_gain1_chk
			property p_gain1;
				@(posedge ref_clk) disable iff (srst)
				wrVol |=> (volGainSel_ff[1] == $past(regWrData[gsa_pkg::POS_GAIN0+1]));
			endproperty
			a_gain1: assert property (p_gain1) else $error("second gain bit not stored"); // [RQ2]
		end
	endgenerate

	property p_supplyUnity;
		@(posedge ref_clk) disable iff (srst)
		chanDoubleGain_ff[0] |->
			($past(chanRefSel[gsa_pkg::REF_SEL_W-1:0]) != gsa_pkg::REF_SUPPLY) &&
			$past(volGainSel_ff[0]);
	endproperty
	a_supplyUnity: assert property (p_supplyUnity) else $error("double gain on supply"); // [RQ4]

	property p_pwrShown;
		@(posedge ref_clk) disable iff (srst)
		rdVol |=> readValid_ff && (readData_ff[gsa_pkg::POS_PWR_EVT] == $past(pwrEvt_ff));
	endproperty
	a_pwrShown: assert property (p_pwrShown) else $error("power flag misread"); // [RQ5]

	property p_pwrClear;
		@(posedge ref_clk) disable iff (srst)
		(rdVol && !porEvent) |=> !pwrEvt_ff ##1 (pwrEvt_ff == $past(porEvent));
	endproperty
	a_pwrClear: assert property (p_pwrClear) else $error("power flag not cleared"); // [RQ6]

	property p_pwrFirstRead;
		@(posedge ref_clk) disable iff (srst)
		(rdVol && pwrEvt_ff) |=> readValid_ff && readData_ff[gsa_pkg::POS_PWR_EVT];
	endproperty
	a_pwrFirstRead: assert property (p_pwrFirstRead) else $error("reset event lost"); // [RQ14]

	property p_nvActive;
		@(posedge ref_clk) disable iff (srst)
		rdVol |=> (readData_ff[gsa_pkg::POS_NV_ACTIVE] == $past(nvWriteActive));
	endproperty
	a_nvActive: assert property (p_nvActive) else $error("write active misread"); // [RQ7]

	property p_nvBlock;
		@(posedge ref_clk) disable iff (srst)
		(regWr && hitNv && nvWriteActive) |=>
			cmdRefused_ff && !nvWriteReq_ff && $stable(nvGainSel_ff) &&
			$stable(slaveAddrBits_ff);
	endproperty
	a_nvBlock: assert property (p_nvBlock) else $error("nv write during busy"); // [RQ8]

	property p_nvRead;
		@(posedge ref_clk) disable iff (srst)
		rdNvOk |=> readHit_ff &&
			(readData_ff[gsa_pkg::POS_LOCK] == $past(addrLockStatus_ff)) &&
			(readData_ff[gsa_pkg::POS_GAIN0 +: NUM_CHAN] == $past(nvGainSel_ff));
	endproperty
	a_nvRead: assert property (p_nvRead) else $error("nv word misread"); // [RQ9] [RQ10]

	property p_volMapped;
		@(posedge ref_clk) disable iff (srst)
		(regRd && !hitVol && !hitNv) |=> readValid_ff && !readHit_ff && (readData_ff == '0);
	endproperty
	a_volMapped: assert property (p_volMapped) else $error("unmapped read answered"); // [RQ11]

	property p_lockHold;
		@(posedge ref_clk) disable iff (srst)
		(wrNvOk && addrLockStatus_ff) |=> $stable(slaveAddrBits_ff) && nvWriteReq_ff;
	endproperty
	a_lockHold: assert property (p_lockHold) else $error("locked address changed"); // [RQ12]

	property p_addrStore;
		@(posedge ref_clk) disable iff (srst)
		wrAddrOk |=> (slaveAddrBits_ff == $past(regWrData[gsa_pkg::SLAVE_ADDR_W-1:0])) &&
			nvWriteReq_ff;
	endproperty
	a_addrStore: assert property (p_addrStore) else $error("address not stored"); // [RQ13]

endmodule : gsa_regs

`default_nettype wire

//--- gsa_host_model.sv
// Purpose: Host-side model that issues register reads and writes.
// Assumes: One-cycle strobes, answer one cycle after the strobe edge.
// Notes:   Released address lines show the inverse of the last value; data lines are inverted only after a write.

`timescale 1ns/1ps
`default_nettype none

module gsa_host_model (
	// Clock
	input  wire logic        ref_clk,
	// Register port toward the device
	output var  logic [4:0]  regAddr,
	output var  logic        regWr,
	output var  logic [15:0] regWrData,
	output var  logic        regRd,
	// Answers from the device
	input  wire logic [15:0] readData_ff,
	input  wire logic        readValid_ff,
	input  wire logic        readHit_ff,
	input  wire logic        cmdRefused_ff,
	input  wire logic        nvWriteReq_ff
);
	// ==========================================================
	// Idle bus at time zero
	initial
	begin
		regAddr = 5'h00;
		regWr = 1'b0;
		regWrData = 16'h0000;
		regRd = 1'b0;
	end

	// One read; answer packed as {0, valid, hit, refused, data}
	task automatic rd(input logic [4:0] a, output logic [19:0] ans);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		regAddr <= ~a;  // Stale address would hide decode slips
		#1;
		ans = {1'b0, readValid_ff, readHit_ff, cmdRefused_ff, readData_ff};
	endtask : rd

	// One write; status packed as {request, refused}
	task automatic wr(input logic [4:0] a, input logic [15:0] d, output logic [1:0] st);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
		#1;
		st = {nvWriteReq_ff, cmdRefused_ff};
	endtask : wr
endmodule : gsa_host_model

`default_nettype wire

//--- gsa_regs_tb.sv
// Purpose: Self-checking bench for the gain, status and slave address registers.
// Assumes: Dual-channel build; status inputs driven on ref_clk.
// Notes:   Answers are packed vectors so one compare covers flags and data.

`timescale 1ns/1ps
`default_nettype none

module gsa_regs_tb;
	// ==========================================================
	// Signals
	logic        ref_clk, srst, porEvent, nvWriteActive;
	logic [1:0]  lockCmds;
	logic [3:0]  chanRefSel;
	logic [4:0]  regAddr;
	logic        regWr, regRd;
	logic [15:0] regWrData, readData_ff, nvWriteData_ff;
	logic        readValid_ff, readHit_ff, cmdRefused_ff, nvWriteReq_ff, addrLockStatus_ff;
	logic [1:0]  chanDoubleGain_ff, nvGainSel_ff;
	logic [6:0]  slaveAddrBits_ff;
	logic [19:0] a;
	logic [1:0]  s;
	int          fails, checks;

	gsa_regs #(.NUM_CHAN(2)) dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
		.regWr(regWr), .regWrData(regWrData), .regRd(regRd), .readData_ff(readData_ff),
		.readValid_ff(readValid_ff), .readHit_ff(readHit_ff), .cmdRefused_ff(cmdRefused_ff),
		.porEvent(porEvent), .nvWriteActive(nvWriteActive), .chanRefSel(chanRefSel),
		.lockSetCmd(lockCmds[0]), .hvUnlockCmd(lockCmds[1]),
		.chanDoubleGain_ff(chanDoubleGain_ff), .nvGainSel_ff(nvGainSel_ff),
		.slaveAddrBits_ff(slaveAddrBits_ff), .addrLockStatus_ff(addrLockStatus_ff),
		.nvWriteReq_ff(nvWriteReq_ff), .nvWriteData_ff(nvWriteData_ff));

	gsa_host_model host (.ref_clk(ref_clk), .regAddr(regAddr), .regWr(regWr),
		.regWrData(regWrData), .regRd(regRd), .readData_ff(readData_ff),
		.readValid_ff(readValid_ff), .readHit_ff(readHit_ff),
		.cmdRefused_ff(cmdRefused_ff), .nvWriteReq_ff(nvWriteReq_ff));

	// ==========================================================
	// Clock, checks and verdict
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// Pulse lock commands: bit 0 sets, bit 1 unlocks
	task automatic pulse(input logic [1:0] v);
		@(posedge ref_clk);
		lockCmds <= v;
		@(posedge ref_clk);
		lockCmds <= 2'h0;
		#1;
	endtask : pulse

	// ==========================================================
	// Scenarios
	task automatic t_reset();
		host.rd(gsa_pkg::ADDR_VOL_GAIN, a);
		chk(a, 20'h60080);
		host.rd(gsa_pkg::ADDR_VOL_GAIN, a);
		chk(a, 20'h60000);
		host.rd(gsa_pkg::ADDR_NV_GAIN, a);
		chk(a, 20'h60000);
		host.rd(5'h05, a);
		chk(a, 20'h40000);
	endtask : t_reset

	// Gain bits, ignored bits and the supply-reference override
	task automatic t_gain();
		host.wr(gsa_pkg::ADDR_VOL_GAIN, 16'hffff, s);
		host.rd(gsa_pkg::ADDR_VOL_GAIN, a);
		chk(a, 20'h60300);
		chk({18'h0, chanDoubleGain_ff}, 20'h3);
		@(posedge ref_clk);
		chanRefSel <= 4'hc;
		@(posedge ref_clk);
		#1;
		chk({18'h0, chanDoubleGain_ff}, 20'h2);
		@(posedge ref_clk);
		chanRefSel <= 4'h3;
		@(posedge ref_clk);
		#1;
		chk({18'h0, chanDoubleGain_ff}, 20'h1);
		@(posedge ref_clk);
		chanRefSel <= 4'hf;
		host.wr(gsa_pkg::ADDR_VOL_GAIN, 16'h0200, s);
		host.rd(gsa_pkg::ADDR_VOL_GAIN, a);
		chk(a, 20'h60200);
	endtask : t_gain

	// Power event flag and write-active flag, then busy refusal
	task automatic t_status();
		@(posedge ref_clk);
		porEvent <= 1'b1;
		nvWriteActive <= 1'b1;
		@(posedge ref_clk);
		porEvent <= 1'b0;
		host.rd(gsa_pkg::ADDR_VOL_GAIN, a);
		chk(a, 20'h602c0);
		host.rd(gsa_pkg::ADDR_VOL_GAIN, a);
		chk(a, 20'h60240);
		host.wr(gsa_pkg::ADDR_NV_GAIN, 16'h03ff, s);
		chk({18'h0, s}, 20'h1);
		chk({11'h0, nvGainSel_ff, slaveAddrBits_ff}, 20'h0);
		host.rd(gsa_pkg::ADDR_NV_GAIN, a);
		chk(a, 20'h50000);
	endtask : t_status

	// Nonvolatile word, then address lock and unlock
	task automatic t_nv();
		@(posedge ref_clk);
		nvWriteActive <= 1'b0;
		host.wr(gsa_pkg::ADDR_NV_GAIN, 16'h03ff, s);
		chk({2'h0, s, nvWriteData_ff}, 20'h2037f);
		chk({11'h0, nvGainSel_ff, slaveAddrBits_ff}, 20'h1ff);
		host.rd(gsa_pkg::ADDR_NV_GAIN, a);
		chk(a, 20'h6037f);
		pulse(2'h1);
		chk({19'h0, addrLockStatus_ff}, 20'h1);
		host.wr(gsa_pkg::ADDR_NV_GAIN, 16'h0112, s);
		host.rd(gsa_pkg::ADDR_NV_GAIN, a);
		chk(a, 20'h601ff);
		pulse(2'h2);
		host.wr(gsa_pkg::ADDR_NV_GAIN, 16'h0012, s);
		host.rd(gsa_pkg::ADDR_NV_GAIN, a);
		chk(a, 20'h60012);
	endtask : t_nv

	// ==========================================================
	// Main sequence and watchdog
	initial
	begin
		srst = 1'b1;
		porEvent = 1'b0;
		nvWriteActive = 1'b0;
		lockCmds = 2'h0;
		chanRefSel = 4'hf;
		fails = 0;
		checks = 0;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset();
		t_gain();
		t_status();
		t_nv();
		give_verdict();
	end

	// Run needs well under 200 cycles
	initial
	begin
		#20000;
		fails++;
		give_verdict();
	end
endmodule : gsa_regs_tb

`default_nettype wire
